// ===== logic/dnml_phy_rx.sv
`timescale 1ns/1ps
// Behaviour
// - Link signals launched and sampled on rising edge of the link clock.
// - This device generates the transmit link clock; all link inputs follow it.
// - One four-bit nibble moves per link clock cycle.
// - Link clock rate follows modulation (64 or 256 QAM) and framing variant.
// - Device offers the data link plus a serial register slave port.
// - Multi-device packages repeat the interface set, may share one serial bus.
// - Device is only ever a slave on the serial register bus.
// - Device drives an interrupt output showing its event state.
// - Bytes move most significant first; upper nibble before lower nibble.
// - Names ending in _n are active low, others active high; the reset input nrst is active low as well.
// - Parity mismatch raises interrupt; data processing continues without halting.
module dnml_phy_rx #(
    parameter int DEPTH = dnml_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire dnml_pkg::dnml_mod_t mod_sel,
    input wire logic framing_b,
    output logic downstream_tx_clock,
    input wire dnml_pkg::dnml_link_t link_in,
    output logic byte_valid,
    input wire logic byte_ready,
    output dnml_pkg::dnml_byte_t byte_out,
    output logic parity_err_pulse,
    input wire logic int_clear,
    output logic int_n_o,
    output logic int_n_oe
);
    import dnml_pkg::*;

    typedef enum logic {
        NIB_HI,
        NIB_LO
    } dnml_nib_t;

    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    logic [HALF_W-1:0] half_cnt, div_r, div_nxt;
    logic lclk_r, lclk_nxt, rise_r, rise_nxt;
    logic fifo_in_ready;

    always_comb begin
        case ({framing_b, mod_sel})
            {1'b0, DNML_RATE_64}: half_cnt = HALF_W'(HALF_A64 - 1);
            {1'b0, DNML_RATE_256}: half_cnt = HALF_W'(HALF_A256 - 1);
            {1'b1, DNML_RATE_64}: half_cnt = HALF_W'(HALF_B64 - 1);
            default: half_cnt = HALF_W'(HALF_B256 - 1);
        endcase
    end

    always_comb begin
        div_nxt = div_r;
        lclk_nxt = lclk_r;
        rise_nxt = 1'b0;
        if (div_r != '0) begin
            div_nxt = div_r - 1'b1;
        end else if (lclk_r) begin
            lclk_nxt = 1'b0;
            div_nxt = half_cnt;
        end else if (fifo_in_ready) begin
            // Holding the clock low is our only back-pressure on the partner
            lclk_nxt = 1'b1;
            div_nxt = half_cnt;
            rise_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            lclk_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            lclk_r <= lclk_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign downstream_tx_clock = lclk_r;

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    dnml_link_t s1_r, s2_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_r <= LINK_RESET;
            s2_r <= LINK_RESET;
        end else begin
            s1_r <= link_in;
            s2_r <= s1_r;
        end
    end

    // ----------------------------------------
    // Nibble to byte assembly
    // ----------------------------------------
    // s2_r at a rise holds pins from before the edge: the previous launch
    dnml_nib_t st_r, st_nxt;
    logic [NIBBLE_W-1:0] hi_r, hi_nxt;
    logic sync_pend_r, sync_pend_nxt;
    logic push_r, push_nxt;
    dnml_byte_t push_data_r, push_data_nxt;
    logic take, par_bad;

    assign take = rise_r && !s2_r.tx_nibble_valid_n;
    assign par_bad = ^{s2_r.tx_nibble, s2_r.tx_nibble_parity};

    always_comb begin
        st_nxt = st_r;
        hi_nxt = hi_r;
        sync_pend_nxt = sync_pend_r;
        push_nxt = 1'b0;
        push_data_nxt = push_data_r;
        if (take) begin
            if (!s2_r.packet_sync_mark_n) begin
                // Sync mark realigns byte boundary
                hi_nxt = s2_r.tx_nibble;
                sync_pend_nxt = 1'b1;
                st_nxt = NIB_LO;
            end else begin
                case (st_r)
                    NIB_HI: begin
                        hi_nxt = s2_r.tx_nibble;
                        sync_pend_nxt = 1'b0;
                        st_nxt = NIB_LO;
                    end
                    NIB_LO: begin
                        push_nxt = 1'b1;
                        push_data_nxt = '{sync_pend_r, {hi_r, s2_r.tx_nibble}};
                        st_nxt = NIB_HI;
                    end
                    default: st_nxt = NIB_HI;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_r <= NIB_HI;
            hi_r <= '0;
            sync_pend_r <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            st_r <= st_nxt;
            hi_r <= hi_nxt;
            sync_pend_r <= sync_pend_nxt;
            push_r <= push_nxt;
            push_data_r <= push_data_nxt;
        end
    end

    // ----------------------------------------
    // Parity error event and interrupt
    // ----------------------------------------
    // Flags are exported for a serial register slave; this block never masters a bus
    logic perr_r, perr_nxt, perr_p_r, perr_p_nxt;

    always_comb begin
        perr_p_nxt = take && par_bad;
        perr_nxt = perr_r;
        if (int_clear) begin
            perr_nxt = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (perr_p_nxt) begin
            perr_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            perr_r <= 1'b0;
            perr_p_r <= 1'b0;
        end else begin
            perr_r <= perr_nxt;
            perr_p_r <= perr_p_nxt;
        end
    end

    assign parity_err_pulse = perr_p_r;
    // Open drain, active low level; one source per instance, so one per device
    assign int_n_o = 1'b0;
    assign int_n_oe = perr_r;

    // ----------------------------------------
    // Output buffer
    // ----------------------------------------
    dnml_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(push_data_r),
        .out_valid(byte_valid),
        .out_ready(byte_ready),
        .out_data(byte_out)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_valid_rise;
        rise_r && !s2_r.tx_nibble_valid_n;
    endsequence

    sequence s_high_nib;
        s_valid_rise and (s2_r.packet_sync_mark_n && st_r == NIB_HI);
    endsequence

    sequence s_low_nib;
        s_valid_rise and (s2_r.packet_sync_mark_n && st_r == NIB_LO);
    endsequence

    a_rise_edge_sample: assert property (rise_r |-> lclk_r && !$past(lclk_r))
        else $error("sample event not on link clock rise");
    a_clock_stall_hold: assert property (!lclk_r && !fifo_in_ready |=> !lclk_r)
        else $error("link clock rose while buffer full");
    a_half_period_min: assert property ($rose(lclk_r) |-> lclk_r [*8])
        else $error("link clock high phase too short");
    a_parity_flag_set: assert property (s_valid_rise ##0 par_bad |=> perr_r && parity_err_pulse)
        else $error("parity error not flagged");
    a_flag_sticky_hold: assert property (perr_r && !int_clear |=> perr_r)
        else $error("error flag dropped without clear");
    a_int_line_drive: assert property (perr_r |-> int_n_oe && !int_n_o)
        else $error("interrupt not driven low");
    a_invalid_ignored: assert property (rise_r && s2_r.tx_nibble_valid_n |=> !push_r && $stable(st_r))
        else $error("nibble taken while strobe idle");
    // Split in two steps: the clock may stall for any time between the nibbles
    a_high_nib_hold: assert property (s_high_nib
        |=> st_r == NIB_LO && hi_r == $past(s2_r.tx_nibble) && !sync_pend_r)
        else $error("upper nibble not held first");
    a_byte_order: assert property (s_low_nib
        |=> push_r && push_data_r.data[7:4] == $past(hi_r)
        && push_data_r.data[3:0] == $past(s2_r.tx_nibble))
        else $error("byte nibble order wrong");
    a_sync_realign: assert property (s_valid_rise ##0 !s2_r.packet_sync_mark_n
        |=> st_r == NIB_LO && sync_pend_r && !push_r)
        else $error("sync mark did not realign byte");
    a_push_has_room: assert property (push_r |-> fifo_in_ready)
        else $error("byte lost at full buffer");

endmodule

// ===== logic/dnml_pkg.sv
package dnml_pkg;

    // ----------------------------------------
    // Clock and link rates
    // ----------------------------------------
    localparam int CLK_SYS_PERIOD_PS = 4000;
    // Nominal link clock periods per modulation and framing
    localparam int LINK_PERIOD_A64_PS = 80000;
    localparam int LINK_PERIOD_A256_PS = 64000;
    localparam int LINK_PERIOD_B64_PS = 96000;
    localparam int LINK_PERIOD_B256_PS = 72000;
    // Half period in system cycles, rounded down
    localparam int HALF_A64 = LINK_PERIOD_A64_PS / CLK_SYS_PERIOD_PS / 2;
    localparam int HALF_A256 = LINK_PERIOD_A256_PS / CLK_SYS_PERIOD_PS / 2;
    localparam int HALF_B64 = LINK_PERIOD_B64_PS / CLK_SYS_PERIOD_PS / 2;
    localparam int HALF_B256 = LINK_PERIOD_B256_PS / CLK_SYS_PERIOD_PS / 2;
    localparam int HALF_W = 6;

    // ----------------------------------------
    // Buffering
    // ----------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int NIBBLE_W = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic LINK_IDLE_N = 1'b1;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic packet_sync_mark_n;
        logic tx_nibble_valid_n;
        logic [NIBBLE_W-1:0] tx_nibble;
        logic tx_nibble_parity;
    } dnml_link_t;

    typedef struct packed {
        logic sync;
        logic [2*NIBBLE_W-1:0] data;
    } dnml_byte_t;

    localparam int BYTE_W = $bits(dnml_byte_t);
    localparam dnml_link_t LINK_RESET = '{LINK_IDLE_N, LINK_IDLE_N, 4'h0, 1'b0};

    typedef enum logic {
        DNML_RATE_64,
        DNML_RATE_256
    } dnml_mod_t;

endpackage

// ===== logic/dnml_fifo.sv
`timescale 1ns/1ps
module dnml_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // ----------------------------------------
    // Pointers
    // ----------------------------------------
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; empty flag guards reads
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

endmodule

// ===== testbench/dnml_mac_model.sv
`timescale 1ns/1ps
module dnml_mac_model (
    input wire logic nrst,
    input wire logic downstream_tx_clock,
    output dnml_pkg::dnml_link_t link_in = dnml_pkg::LINK_RESET
);
    import dnml_pkg::*;
    // ----------------------------------------
    // Nibble queue, launched on link clock rises
    // ----------------------------------------
    logic [6:0] q[$];
    task automatic put_nibble(input logic [3:0] d, input logic sync, input logic bad);
        q.push_back({~sync, 1'b0, d, (^d) ^ bad});
    endtask
    task automatic put_byte(input logic [7:0] d, input logic sync, input logic bad);
        put_nibble(d[7:4], sync, bad);
        put_nibble(d[3:0], 1'b0, 1'b0);
    endtask
    // Idle words carry a sync mark, new data and bad parity, so ignoring them is tested
    always @(posedge downstream_tx_clock or negedge nrst) begin
        if (!nrst) begin
            link_in <= LINK_RESET;
        end else if (q.size() > 0) begin
            link_in <= q.pop_front();
        end else begin
            link_in <= {2'b01, ~link_in.tx_nibble, ~^link_in.tx_nibble};
        end
    end
endmodule

// ===== testbench/downstream_nibble_mac_phy_link_bench.sv
`timescale 1ns/1ps
module downstream_nibble_mac_phy_link_bench;
    import dnml_pkg::*;
    logic clk_sys;
    logic nrst;
    logic framing_b;
    logic byte_ready;
    logic int_clear;
    logic byte_valid;
    logic parity_err_pulse;
    logic int_n_o;
    logic int_n_oe;
    logic downstream_tx_clock;
    dnml_mod_t mod_sel;
    dnml_link_t link_in;
    dnml_byte_t byte_out;
    logic [8:0] rx_q[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int rises = 0;
    int perr = 0;

    dnml_phy_rx #(.DEPTH(FIFO_DEPTH)) dut (.clk_sys(clk_sys), .nrst(nrst), .mod_sel(mod_sel),
        .framing_b(framing_b), .downstream_tx_clock(downstream_tx_clock), .link_in(link_in),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_out(byte_out),
        .parity_err_pulse(parity_err_pulse), .int_clear(int_clear), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
    dnml_mac_model mac (.nrst(nrst), .downstream_tx_clock(downstream_tx_clock), .link_in(link_in));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Monitors and timeout
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
            rx_q.push_back(byte_out);
        end
        if (parity_err_pulse === 1'b1) begin
            perr <= perr + 1;
        end
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    always @(posedge downstream_tx_clock) begin
        rises++;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait, the design may lose bytes
    task automatic wait_rx(input int n);
        int k;
        k = 0;
        while (rx_q.size() < n && k < 4000) begin
            tick(1);
            k++;
        end
    endtask
    task automatic t_reset();
        #1;
        check("tx_clock", 0, downstream_tx_clock);
        check("byte_valid", 0, byte_valid);
        check("err_pulse", 0, parity_err_pulse);
        check("int_oe", 0, int_n_oe);
    endtask
    task automatic t_rates();
        int per[4];
        int i;
        time t0;
        per = '{LINK_PERIOD_A64_PS, LINK_PERIOD_A256_PS, LINK_PERIOD_B64_PS, LINK_PERIOD_B256_PS};
        for (i = 3; i >= 0; i--) begin
            @(posedge clk_sys);
            mod_sel <= dnml_mod_t'(i[0]);
            framing_b <= i[1];
            repeat (2) @(posedge downstream_tx_clock);
            t0 = $time;
            @(posedge downstream_tx_clock);
            check("link_period", per[i] / 1000, $time - t0);
        end
        check("idle_bytes", 0, rx_q.size());
        check("idle_errors", 0, perr);
    endtask
    task automatic t_stream();
        logic [7:0] d[4];
        int i;
        d = '{8'h47, 8'h1e, 8'ha5, 8'h3c};
        rx_q.delete();
        for (i = 0; i < 4; i++) begin
            mac.put_byte(d[i], i == 0, 1'b0);
        end
        wait_rx(4);
        for (i = 0; i < 4; i++) begin
            check("byte", {i == 0, d[i]}, rx_q[i]);
        end
        check("good_parity", 0, perr);
    endtask
    task automatic t_parity();
        rx_q.delete();
        mac.put_byte(8'h47, 1'b1, 1'b1);
        mac.put_byte(8'h5a, 1'b0, 1'b0);
        wait_rx(2);
        check("err_count", 1, perr);
        check("int_oe_set", 1, int_n_oe);
        check("int_level", 0, int_n_o);
        check("bad_byte", 9'h147, rx_q[0]);
        check("next_byte", 9'h05a, rx_q[1]);
        @(posedge clk_sys);
        int_clear <= 1'b1;
        @(posedge clk_sys);
        int_clear <= 1'b0;
        tick(1);
        check("int_oe_clr", 0, int_n_oe);
    endtask
    // Lone high nibble is dropped when a sync mark restarts the byte
    task automatic t_resync();
        rx_q.delete();
        mac.put_nibble(4'h9, 1'b0, 1'b0);
        mac.put_byte(8'hc3, 1'b1, 1'b0);
        wait_rx(1);
        tick(100);
        check("resync_count", 1, rx_q.size());
        check("resync_byte", 9'h1c3, rx_q[0]);
    endtask
    task automatic t_full();
        int i;
        int r0;
        rx_q.delete();
        @(posedge clk_sys);
        byte_ready <= 1'b0;
        for (i = 0; i < 20; i++) begin
            mac.put_byte(8'(i * 13), i == 0, 1'b0);
        end
        tick(1200);
        check("full_valid", 1, byte_valid);
        r0 = rises;
        tick(200);
        check("clock_stalled", r0, rises);
        @(posedge clk_sys);
        byte_ready <= 1'b1;
        wait_rx(20);
        for (i = 0; i < 20; i++) begin
            check("drained", {i == 0, 8'(i * 13)}, rx_q[i]);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        mod_sel = DNML_RATE_64;
        framing_b = 1'b0;
        byte_ready = 1'b1;
        int_clear = 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        @(posedge clk_sys);
        nrst <= 1'b1;
        t_rates();
        t_stream();
        t_parity();
        t_resync();
        t_full();
        complete_run();
    end
endmodule
